// ### hw/fem_top.sv
// Purpose: fp exception enable and mode view with trap generation
// Assumes: core moves arrive on ref_clk_i; datapath reports per operation
// Notes: enable view and full word share one set of flops
// Notes: trap_o and rvalid_o are one-cycle pulses, a clock after the move or op
// Notes: a full-word write, or an enable view write with no unimplemented op, checks trap_enable_field against the causes it leaves
// Notes: an unimplemented-operation trap carries an all-zero trap_vec_o
// Notes: fields load zero at reset, standing in for the unknown power-up value
`timescale 1ns/1ps
module fem_top import fem_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // coprocessor moves
  input wire fem_move_t move_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // arithmetic reports
  input wire fem_op_t op_i,
  // trap and mode outputs
  output logic trap_o,
  output logic [4:0] trap_vec_o,
  output fem_mode_t mode_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    // fields shared by both views
    logic [4:0] en;
    logic flush;
    fem_rnd_t rnd;
    // status held only in the full word
    logic [4:0] cause;
    logic unimp;
    logic [4:0] flag;
    // registered outputs
    logic [31:0] rdata;
    logic rvalid;
    logic trap;
    logic [4:0] trap_vec;
    fem_mode_t mode;
  } fem_state_t;

  fem_state_t s_q;
  fem_state_t s_d;
  logic wr_en_view;
  logic wr_csw;
  logic [4:0] new_cause;
  logic [4:0] hit_vec;
  logic hit;
  logic [31:0] view_word;
  logic [31:0] csw_word;
  logic unimp_op;
  logic trap_chk;

  // tiny-result actions handed to the datapath
  localparam logic [1:0] TINY_ZERO = 2'h0;
  localparam logic [1:0] TINY_MIN = 2'h1;
  localparam logic [1:0] TINY_KEEP = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // move decode: any other register number falls through and is ignored
  assign wr_en_view = move_i.wr && (move_i.num == FEM_REG_ENABLE);
  assign wr_csw = move_i.wr && (move_i.num == FEM_REG_CSW);

  // a denormal input with flushing off cannot be computed here
  assign unimp_op = op_i.valid && op_i.denorm_in && !s_q.flush;

  // pairing is checked after an op or a write to either view; an
  // unimplemented op skips it unless a full-word write comes in the same cycle, as its causes carry no meaning
  assign trap_chk = wr_csw || (!unimp_op && (wr_en_view || op_i.valid));

  //////////////////////////////////////////////////////////////////////////////
  // read views built from the same flops, other bits forced to zero
  always_comb begin
    // enable view: 31:12 and 6:3 are never driven
    view_word = 32'h0000_0000;
    view_word[FEM_EN_MSB:FEM_EN_LSB] = s_q.en;
    view_word[FEM_FLUSH_BIT] = s_q.flush;
    view_word[FEM_RND_MSB:FEM_RND_LSB] = s_q.rnd;
    // full word: same flops, flush moved up to bit 24
    csw_word = 32'h0000_0000;
    csw_word[FEM_EN_MSB:FEM_EN_LSB] = s_q.en;
    csw_word[FEM_CSW_FLUSH_BIT] = s_q.flush;
    csw_word[FEM_RND_MSB:FEM_RND_LSB] = s_q.rnd;
    csw_word[FEM_CSW_CAUSE_MSB:FEM_CSW_CAUSE_LSB] = s_q.cause;
    csw_word[FEM_CSW_UNIMP_BIT] = s_q.unimp;
    csw_word[FEM_CSW_FLAG_MSB:FEM_CSW_FLAG_LSB] = s_q.flag;
  end

  //////////////////////////////////////////////////////////////////////////////
  // cause seen by the trap check: a full-word write wins over an arithmetic report
  always_comb begin
    // on an enable view write with no op the held causes are checked as they stand
    new_cause = s_q.cause;
    if (wr_csw) begin
      new_cause = move_i.wdata[FEM_CSW_CAUSE_MSB:FEM_CSW_CAUSE_LSB];
    end else if (op_i.valid) begin
      new_cause = op_i.cause;
    end
  end

  // trap_enable_field in effect for this cycle's check, including a same-cycle write
  logic [4:0] chk_en;
  always_comb begin
    // a view write is checked against the trap_enable_field it carries
    chk_en = s_q.en;
    if (wr_en_view || wr_csw) begin
      chk_en = move_i.wdata[FEM_EN_MSB:FEM_EN_LSB];
    end
  end

  // one enable-and-cause pair per condition
  fem_trap_check #(
    .N(5)
  ) u_check (
    .enable_i(chk_en),
    .cause_i(new_cause),
    .hit_o(hit),
    .hit_vec_o(hit_vec)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.trap = 1'b0;
    s_d.trap_vec = 5'h00;
    // writes to either view land in the one copy of each field
    if (wr_en_view || wr_csw) begin
      s_d.en = move_i.wdata[FEM_EN_MSB:FEM_EN_LSB];
      s_d.rnd = fem_rnd_t'(move_i.wdata[FEM_RND_MSB:FEM_RND_LSB]);
    end
    // flush sits at a different bit in each view
    if (wr_en_view) begin
      s_d.flush = move_i.wdata[FEM_FLUSH_BIT];
    end

    // a full-word write loads status directly and wins over a same-cycle op
    if (wr_csw) begin
      s_d.flush = move_i.wdata[FEM_CSW_FLUSH_BIT];
      s_d.cause = new_cause;
      s_d.unimp = move_i.wdata[FEM_CSW_UNIMP_BIT];
      s_d.flag = move_i.wdata[FEM_CSW_FLAG_MSB:FEM_CSW_FLAG_LSB];
    end else if (op_i.valid) begin
      // denormal input without flushing is an unimplemented operation
      s_d.unimp = unimp_op;
      s_d.cause = unimp_op ? 5'h00 : op_i.cause;
      // flags gather a computed op's causes whose held trap_enable_field bit is clear, and stay set
      s_d.flag = s_q.flag | (unimp_op ? 5'h00 : (op_i.cause & ~s_q.en));
    end

    // trap fires on the cycle after the pairing appears
    if (trap_chk) begin
      s_d.trap = hit;
      s_d.trap_vec = hit_vec;
    end
    // an unimplemented op traps unless a full-word write comes in the same cycle, with nothing in the vector
    if (unimp_op && !wr_csw) begin
      s_d.trap = 1'b1;
    end

    // reads return the view asked for; unknown numbers read zero
    if (move_i.rd) begin
      s_d.rvalid = 1'b1;
      case (move_i.num)
        FEM_REG_ENABLE: s_d.rdata = view_word;
        FEM_REG_CSW: s_d.rdata = csw_word;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // mode outputs follow the committed fields
    s_d.mode.flush_in = s_d.flush;
    s_d.mode.rnd = s_d.rnd;
    // tiny action: zero or smallest normal while flushing, else left alone
    if (!s_d.flush) begin
      s_d.mode.tiny_action = TINY_KEEP;
    end else begin
      // directed rounding lifts tiny results on its own side to smallest normal
      case (s_d.rnd)
        FEM_RND_PLUS_INF: s_d.mode.tiny_action = op_i.sign ? TINY_ZERO : TINY_MIN;
        FEM_RND_MINUS_INF: s_d.mode.tiny_action = op_i.sign ? TINY_MIN : TINY_ZERO;
        default: s_d.mode.tiny_action = TINY_ZERO; // nearest and toward zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; software must load fields before arithmetic
  // the asynchronous branch loads constants only
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0; // zero stands in for the unknown power-up value
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ports come straight from the state flops
  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;
  assign trap_o = s_q.trap;
  assign trap_vec_o = s_q.trap_vec;
  assign mode_o = s_q.mode;

endmodule

// ### hw/fem_trap_check.sv
// Purpose: combinational trap detection for fp exceptions
// Assumes: trap_enable_field and causes share the same bit order
// Notes: one generate per condition
`timescale 1ns/1ps
module fem_trap_check import fem_pkg::*; #(
  parameter int N = 5
) (
  // fields
  input wire logic [N-1:0] enable_i,
  input wire logic [N-1:0] cause_i,
  // result
  output logic hit_o,
  output logic [N-1:0] hit_vec_o
);

  // per-condition pairing of enable and cause
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pair
      assign hit_vec_o[g] = enable_i[g] & cause_i[g];
    end
  endgenerate

  assign hit_o = |hit_vec_o;

endmodule

// ### inc/fem_pkg.sv
// Purpose: shared constants and types for the fp exception/mode view
// Assumes: coprocessor register moves from the core on one clock
// Notes: register number is the coprocessor register index, not a byte address
package fem_pkg;

  // coprocessor 1 register numbers
  localparam logic [4:0] FEM_REG_ENABLE = 5'h1C; // exception/mode enable view
  localparam logic [4:0] FEM_REG_CSW = 5'h1F; // full control/status word

  // field positions in the enable view
  localparam int FEM_EN_LSB = 7;
  localparam int FEM_EN_MSB = 11;
  localparam int FEM_FLUSH_BIT = 2;
  localparam int FEM_RND_LSB = 0;
  localparam int FEM_RND_MSB = 1;

  // field positions in the full word: trap_enable_field 11:7, flush 24, rounding 1:0, causes 16:12
  localparam int FEM_CSW_FLUSH_BIT = 24;
  localparam int FEM_CSW_CAUSE_LSB = 12;
  localparam int FEM_CSW_CAUSE_MSB = 16;
  localparam int FEM_CSW_UNIMP_BIT = 17;
  localparam int FEM_CSW_FLAG_LSB = 2;
  localparam int FEM_CSW_FLAG_MSB = 6;

  // condition bit order inside the five-bit fields
  localparam int FEM_C_INEXACT = 0;
  localparam int FEM_C_UNDERFLOW = 1;
  localparam int FEM_C_OVERFLOW = 2;
  localparam int FEM_C_DIVZERO = 3;
  localparam int FEM_C_INVALID = 4;

  // reset values: hardware leaves these unknown, zero is a safe choice here
  localparam logic [4:0] FEM_EN_RST = 5'h00;
  localparam logic FEM_FLUSH_RST = 1'b0;
  localparam logic [1:0] FEM_RND_RST = 2'h0;

  typedef enum logic [1:0] {
    FEM_RND_NEAREST,
    FEM_RND_ZERO,
    FEM_RND_PLUS_INF,
    FEM_RND_MINUS_INF
  } fem_rnd_t;

  // core move request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] num;
    logic [31:0] wdata;
  } fem_move_t;

  // arithmetic unit report for one completed operation
  typedef struct packed {
    logic valid;
    logic [4:0] cause;
    logic denorm_in;
    logic tiny;
    logic sign;
  } fem_op_t;

  // mode outputs to the datapath
  typedef struct packed {
    logic flush_in;
    logic [1:0] tiny_action;
    fem_rnd_t rnd;
  } fem_mode_t;

endpackage

// ### tb/fem_core_model.sv
// Purpose: core side issuing coprocessor moves
// Assumes: one move at a time, answer one cycle on
// Notes: idle lines show inverted last values
`timescale 1ns/1ps
module fem_core_model import fem_pkg::*; (
  // clock
  input wire logic ref_clk_i,
  // move out, answer in
  output fem_move_t move_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  initial move_o = '0;
  ////////////////////////////////
  // one move held over its taking edge; stale lines would hide decode faults
  task automatic mv(input logic w, input logic [4:0] n, input logic [31:0] d);
    @(posedge ref_clk_i);
    move_o <= '{wr: w, rd: !w, num: n, wdata: d};
    @(posedge ref_clk_i);
    move_o <= '{wr: 1'b0, rd: 1'b0, num: ~n, wdata: ~d};
  endtask
  // read: answer stands in the cycle after the taking edge
  task automatic rd(input logic [4:0] n, output logic [31:0] d);
    mv(1'b0, n, 32'h0000_0000);
    #1;
    d = rvalid_i ? rdata_i : 32'hFFFF_0000;
  endtask
endmodule

// ### tb/fem_monitor.sv
// Purpose: port checks for the fp enable view
// Assumes: one clock, async low reset
// Notes: view reads are tied to mode_o
`timescale 1ns/1ps
module fem_monitor import fem_pkg::*; (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire fem_move_t move_i,
  input wire logic [31:0] rdata_o,
  input wire logic rvalid_o,
  input wire fem_op_t op_i,
  input wire logic trap_o,
  input wire logic [4:0] trap_vec_o,
  input wire fem_mode_t mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////
  // marks a view read; a write in the same cycle would blur the answer
  logic rd28_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) rd28_q <= 1'b0;
    else rd28_q <= move_i.rd && !move_i.wr && move_i.num == FEM_REG_ENABLE;
  chk_read_answer:
    assert property (move_i.rd |=> rvalid_o) else $error("read not answered");
  chk_gaps_zero:
    assert property (rd28_q |-> rdata_o[31:12] == 20'h00000 && rdata_o[6:3] == 4'h0)
    else $error("gap bits set");
  chk_flush_view:
    assert property (rd28_q |-> rdata_o[2] == mode_o.flush_in) else $error("flush differs");
  chk_round_view:
    assert property (rd28_q |-> rdata_o[1:0] == mode_o.rnd) else $error("rounding differs");
  chk_trap_cause:
    assert property (trap_o |-> $past(op_i.valid || move_i.wr)) else $error("trap from nowhere");
  chk_quiet_op:
    assert property (op_i.valid && op_i.cause == 5'h00 && !op_i.denorm_in && !move_i.wr
      |=> !trap_o) else $error("trap without cause");
  chk_denorm_trap:
    assert property (op_i.valid && op_i.denorm_in && op_i.cause == 5'h00 && !mode_o.flush_in
      && !move_i.wr |=> trap_o && trap_vec_o == 5'h00) else $error("denormal not trapped");
  chk_tiny_zero:
    assert property (mode_o.flush_in && !mode_o.rnd[1] |-> mode_o.tiny_action == 2'h0)
    else $error("tiny action wrong");
endmodule

// ### tb/fem_top_tb.sv
// Purpose: self-checking bench for the fp enable view
// Assumes: moves go through the core model
// Notes: fields are written before any op
`timescale 1ns/1ps
module fem_top_tb import fem_pkg::*; ;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  fem_move_t move;
  fem_op_t op = '0;
  logic [31:0] rdata;
  logic rvalid, trap;
  logic [4:0] trap_vec;
  fem_mode_t mode;
  int errors = 0, n_tests = 0, cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  fem_core_model i_fem_core_model (.ref_clk_i(ref_clk_i), .move_o(move),
    .rdata_i(rdata), .rvalid_i(rvalid));
  fem_top i_fem_top (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .move_i(move),
    .rdata_o(rdata), .rvalid_o(rvalid), .op_i(op), .trap_o(trap),
    .trap_vec_o(trap_vec), .mode_o(mode));
  ////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one op report, trap seen in the cycle after
  task automatic fire(input logic [4:0] c, input logic dn);
    @(posedge ref_clk_i);
    op <= '{valid: 1'b1, cause: c, denorm_in: dn, tiny: 1'b0, sign: 1'b0};
    @(posedge ref_clk_i);
    op <= '0;
    #1;
  endtask
  ////////////////////////////////
  // every rounding code, then gaps and an unmapped number
  task automatic t_modes();
    logic [31:0] d;
    for (int r = 0; r < 4; r++) begin
      i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0004 | 32'(r));
      #1;
      chk(mode.rnd, 32'(r));
      chk(mode.flush_in, 1'b1);
      chk(mode.tiny_action, (r == 2) ? 32'h0000_0001 : 32'h0000_0000);
      i_fem_core_model.rd(FEM_REG_ENABLE, d);
      chk(d, 32'h0000_0004 | 32'(r));
    end
    i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'hFFFF_FFFF);
    i_fem_core_model.mv(1'b1, 5'h05, 32'h0000_0000);
    i_fem_core_model.rd(FEM_REG_ENABLE, d);
    chk(d, 32'h0000_0F87);
    i_fem_core_model.rd(5'h05, d);
    chk(d, 32'h0000_0000);
  endtask
  // full word and view share one field set
  task automatic t_views();
    logic [31:0] d;
    i_fem_core_model.mv(1'b1, FEM_REG_CSW, 32'h0100_0F82);
    i_fem_core_model.rd(FEM_REG_ENABLE, d);
    chk(d, 32'h0000_0F86);
    i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0001);
    i_fem_core_model.rd(FEM_REG_CSW, d);
    chk(d & 32'h0100_0F83, 32'h0000_0001);
    chk(mode.tiny_action, 32'h0000_0002);
  endtask
  // one enable at a time against all causes, then all other causes
  task automatic t_trap_op();
    for (int i = 0; i < 5; i++) begin
      i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0080 << i);
      fire(5'h1F, 1'b0);
      chk(trap, 1'b1);
      chk(trap_vec, 5'h01 << i);
      fire(~(5'h01 << i), 1'b0);
      chk(trap, 1'b0);
    end
  endtask
  // a written word pairing enable and cause traps at once
  task automatic t_trap_wr();
    i_fem_core_model.mv(1'b1, FEM_REG_CSW, 32'h0001_0800);
    #1;
    chk(trap, 1'b1);
    chk(trap_vec, 5'h10);
    i_fem_core_model.mv(1'b1, FEM_REG_CSW, 32'h0000_8800);
    #1;
    chk(trap, 1'b0);
    // enable view write pairs the held divide-by-zero cause
    i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0400);
    #1;
    chk(trap, 1'b1);
    chk(trap_vec, 5'h08);
  endtask
  // denormal input with flush off, then on
  task automatic t_denorm();
    i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0000);
    fire(5'h00, 1'b1);
    chk(trap, 1'b1);
    chk(trap_vec, 5'h00);
    i_fem_core_model.mv(1'b1, FEM_REG_ENABLE, 32'h0000_0004);
    fire(5'h00, 1'b1);
    chk(trap, 1'b0);
  endtask
  ////////////////////////////////
  // hang guard, far above the roughly 80 cycles needed
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_modes(); // fields set up before any op
    t_views();
    t_trap_op();
    t_trap_wr();
    t_denorm();
    finish_test();
  end
endmodule
bind fem_top fem_monitor i_fem_monitor (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
  .move_i(move_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .op_i(op_i), .trap_o(trap_o),
  .trap_vec_o(trap_vec_o), .mode_o(mode_o));
